// ### hw/cthc_top.sv
/*
 * Cycle and time history counter bank with AXI4-Lite register access,
 * temperature "none" code checking and a level interrupt.
 * Assumes event inputs are synchronous to CLK; the display side master
 * reaches the bank through a bus bridge as the only initiator.
 */
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cthc_map.svh"

// Overview of operation
// - burner run time kept as six-digit hours plus minutes
// - six cycle counters: burner, heat loop, hot water, three pumps, 0..999999
// - burner run time and six cycle counters are writable by software
// - controller run time and control cycle count are read-only
// - each temperature input may carry a reserved none code
// - none code raises alarm or lockout and picks fallback or suspend
// - block answers only as a bus slave, never initiates
// - burner cycle count advances on each main gas valve switch-on
module cthc_top
    import cthc_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [11:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [11:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        MAIN_VALVE_ON,
    input  wire logic        CTRL_CYCLE_EVT,
    input  wire logic [4:0]  LOOP_PUMP_ON,
    input  wire logic [63:0] TEMP_PARAMS,
    output logic [3:0]       TEMP_ALARM,
    output logic [3:0]       TEMP_LOCKOUT,
    output logic [3:0]       TEMP_FALLBACK,
    output logic [3:0]       TEMP_SUSPEND,
    output logic             IRQ
);
    // ============================================================
    // state
    // ============================================================
    typedef struct packed {
        cthc_ax_st_t                 wst;
        cthc_ax_st_t                 rst_;
        logic                        aw_got;
        logic                        w_got;
        logic [11:0]                 awaddr;
        logic [31:0]                 wdata;
        logic [3:0]                  wstrb;
        logic [1:0]                  bresp;
        logic [31:0]                 rdata;
        logic [1:0]                  rresp;
        logic                        arready;
        logic [31:0]                 div;
        logic                        valve_prev;
        logic [4:0]                  pump_prev;
        logic [3:0]                  act_lock;
        logic [3:0]                  act_susp;
        logic [`CTHC_IRQ_WIDTH-1:0]  irq_stat;
        logic [`CTHC_IRQ_WIDTH-1:0]  irq_mask;
        logic [3:0]                  alarm;
        logic [3:0]                  lockout;
        logic [3:0]                  fallback;
        logic [3:0]                  suspend;
        logic                        irq;
        logic                        awready;
        logic                        wready;
        logic                        bvalid;
        logic                        rvalid;
    } cthc_top_st_t;

    cthc_top_st_t s_q;
    cthc_top_st_t s_d;

    cthc_tick_if tick ();

    // ============================================================
    // counters
    // ============================================================
    cthc_time_t brn_time;
    cthc_time_t ctl_time;
    cthc_cnt_t  cnt_val [`CTHC_NUM_CNT];
    cthc_cnt_t  ctl_cnt;
    logic [`CTHC_NUM_CNT-1:0] cnt_evt;
    logic [`CTHC_NUM_CNT-1:0] cnt_load;
    logic [`CTHC_NUM_CNT-1:0] cnt_sat;
    logic                     ctl_sat;
    logic                     wr_fire;
    logic                     wr_word;
    cthc_time_t               wr_time;

    // index 0 burner counts valve rising edges; 1..5 loops and pumps
    assign cnt_evt[0] = MAIN_VALVE_ON & ~s_q.valve_prev;
    assign cnt_evt[`CTHC_NUM_CNT-1:1] = LOOP_PUMP_ON & ~s_q.pump_prev;
    assign wr_word = wr_fire && (s_q.wstrb == 4'hF);
    assign wr_time.hours = s_q.wdata[`CTHC_HOUR_POS +: 20];
    assign wr_time.mins  = s_q.wdata[`CTHC_MIN_POS +: 6];

    cthc_runtime u_brn_time (
        .clk      (CLK),
        .rst      (RST),
        .tick     (tick),
        .run      (MAIN_VALVE_ON),
        .load     (wr_word && s_q.awaddr == `CTHC_OFS_BRN_TIME),
        .load_val (wr_time),
        .value    (brn_time)
    );

    cthc_runtime u_ctl_time (
        .clk      (CLK),
        .rst      (RST),
        .tick     (tick),
        .run      (1'b1),
        .load     (1'b0),
        .load_val ('0),
        .value    (ctl_time)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `CTHC_NUM_CNT; gi++)
        begin : g_cnt
            assign cnt_load[gi] = wr_word && s_q.awaddr == (`CTHC_OFS_CNT_BASE + 12'(4 * gi));
            cthc_evcnt u_cnt (
                .clk      (CLK),
                .rst      (RST),
                .evt      (cnt_evt[gi]),
                .load     (cnt_load[gi]),
                .load_val (s_q.wdata[19:0]),
                .value    (cnt_val[gi]),
                .sat_hit  (cnt_sat[gi])
            );
        end
    endgenerate

    cthc_evcnt u_ctl_cnt (
        .clk      (CLK),
        .rst      (RST),
        .evt      (CTRL_CYCLE_EVT),
        .load     (1'b0),
        .load_val ('0),
        .value    (ctl_cnt),
        .sat_hit  (ctl_sat)
    );

    assign tick.min_tick = (s_q.div == 32'(`CTHC_MINUTE_CYC - 1));

    // ============================================================
    // temperature none check
    // ============================================================
    logic [3:0] temp_none;
    generate
        for (gi = 0; gi < `CTHC_NUM_TFUNC; gi++)
        begin : g_temp
            assign temp_none[gi] = (TEMP_PARAMS[16*gi +: 16] == `CTHC_TEMP_NONE);
        end
    endgenerate

    // ============================================================
    // read mux
    // ============================================================
    function automatic logic [31:0] pack_time(input cthc_time_t t);
        logic [31:0] r;
        r = '0;
        r[`CTHC_HOUR_POS +: 20] = t.hours;
        r[`CTHC_MIN_POS +: 6]   = t.mins;
        return r;
    endfunction : pack_time

    logic [31:0] rd_val;
    logic        rd_ok;
    always_comb
    begin
        rd_val = '0;
        rd_ok  = 1'b1;
        if (S_AXI_ARADDR == `CTHC_OFS_BRN_TIME)
            rd_val = pack_time(brn_time);
        else if (S_AXI_ARADDR >= `CTHC_OFS_CNT_BASE && S_AXI_ARADDR < `CTHC_OFS_CTL_TIME
                 && S_AXI_ARADDR[1:0] == 2'h0)
            rd_val = {12'h000, cnt_val[3'((S_AXI_ARADDR - `CTHC_OFS_CNT_BASE) >> 2)]};
        else if (S_AXI_ARADDR == `CTHC_OFS_CTL_TIME)
            rd_val = pack_time(ctl_time);
        else if (S_AXI_ARADDR == `CTHC_OFS_CTL_CNT)
            rd_val = {12'h000, ctl_cnt};
        else if (S_AXI_ARADDR == `CTHC_OFS_EVT_CFG)
            rd_val = {24'h000000, s_q.act_susp, s_q.act_lock};
        else if (S_AXI_ARADDR == `CTHC_OFS_TEMP_IN)
            rd_val = {28'h0000000, temp_none};
        else if (S_AXI_ARADDR == `CTHC_OFS_TEMP_ACT)
            rd_val = {16'h0000, s_q.suspend, s_q.fallback, s_q.lockout, s_q.alarm};
        else if (S_AXI_ARADDR == `CTHC_OFS_IRQ_STAT)
            rd_val = {30'h00000000, s_q.irq_stat};
        else if (S_AXI_ARADDR == `CTHC_OFS_IRQ_MASK)
            rd_val = {30'h00000000, s_q.irq_mask};
        else if (S_AXI_ARADDR == `CTHC_OFS_FUNC_STAT)
            rd_val = {25'h0000000, ctl_sat, cnt_sat};
        else
            rd_ok = 1'b0;
    end

    // ============================================================
    // next state
    // ============================================================
    always_comb
    begin
        s_d = s_q;
        wr_fire = 1'b0;
        s_d.div = tick.min_tick ? 32'h00000000 : s_q.div + 32'h00000001;
        s_d.valve_prev = MAIN_VALVE_ON;
        s_d.pump_prev  = LOOP_PUMP_ON;

        // write channel: address and data taken in either order; slave only
        case (s_q.wst)
            CTHC_AX_IDLE:
            begin
                if (S_AXI_AWVALID && !s_q.aw_got)
                begin
                    s_d.aw_got = 1'b1;
                    s_d.awaddr = S_AXI_AWADDR;
                end
                if (S_AXI_WVALID && !s_q.w_got)
                begin
                    s_d.w_got = 1'b1;
                    s_d.wdata = S_AXI_WDATA;
                    s_d.wstrb = S_AXI_WSTRB;
                end
                if (s_q.aw_got && s_q.w_got)
                begin
                    wr_fire = 1'b1;
                    s_d.aw_got = 1'b0;
                    s_d.w_got  = 1'b0;
                    s_d.wst    = CTHC_AX_RESP;
                    s_d.bresp  = `CTHC_RESP_OKAY;
                    if (s_q.awaddr == `CTHC_OFS_EVT_CFG)
                    begin
                        s_d.act_lock = s_q.wdata[3:0];
                        s_d.act_susp = s_q.wdata[7:4];
                    end
                    else if (s_q.awaddr == `CTHC_OFS_IRQ_MASK)
                        s_d.irq_mask = s_q.wdata[`CTHC_IRQ_WIDTH-1:0];
                    else if (s_q.awaddr == `CTHC_OFS_IRQ_STAT)
                        s_d.irq_stat = s_q.irq_stat & ~s_q.wdata[`CTHC_IRQ_WIDTH-1:0];
                    else if (s_q.awaddr == `CTHC_OFS_CTL_TIME || s_q.awaddr == `CTHC_OFS_CTL_CNT)
                        s_d.bresp = `CTHC_RESP_SLVERR;
                    else if (!(s_q.awaddr <= `CTHC_OFS_FUNC_STAT && s_q.awaddr[1:0] == 2'h0))
                        s_d.bresp = `CTHC_RESP_SLVERR;
                end
            end
            CTHC_AX_RESP:
            begin
                if (S_AXI_BREADY)
                    s_d.wst = CTHC_AX_IDLE;
            end
            default: s_d.wst = CTHC_AX_IDLE;
        endcase

        // read channel
        s_d.arready = 1'b0;
        case (s_q.rst_)
            CTHC_AX_IDLE:
            begin
                if (s_q.arready)
                begin
                    // the answer may only follow the completed address handshake
                    s_d.rst_ = CTHC_AX_RESP;
                end
                else if (S_AXI_ARVALID)
                begin
                    s_d.arready = 1'b1;
                    s_d.rdata   = rd_val;
                    s_d.rresp   = rd_ok ? `CTHC_RESP_OKAY : `CTHC_RESP_SLVERR;
                end
            end
            CTHC_AX_RESP:
            begin
                if (S_AXI_RREADY)
                    s_d.rst_ = CTHC_AX_IDLE;
            end
            default: s_d.rst_ = CTHC_AX_IDLE;
        endcase

        // none code: lockout or alarm per function, then suspend or fallback
        s_d.lockout  = temp_none & s_q.act_lock;
        s_d.alarm    = temp_none & ~s_q.act_lock;
        s_d.suspend  = temp_none & s_q.act_susp;
        s_d.fallback = temp_none & ~s_q.act_susp;

        // set wins over a clear in the same cycle
        if (|cnt_sat || ctl_sat)
            s_d.irq_stat[`CTHC_IRQ_SAT_POS] = 1'b1;
        if (|temp_none)
            s_d.irq_stat[`CTHC_IRQ_NONE_POS] = 1'b1;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
        s_d.awready = (s_d.wst == CTHC_AX_IDLE) && !s_d.aw_got;
        s_d.wready  = (s_d.wst == CTHC_AX_IDLE) && !s_d.w_got;
        s_d.bvalid  = (s_d.wst == CTHC_AX_RESP);
        s_d.rvalid  = (s_d.rst_ == CTHC_AX_RESP);
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ============================================================
    // outputs
    // ============================================================
    assign S_AXI_AWREADY = s_q.awready;
    assign S_AXI_WREADY  = s_q.wready;
    assign S_AXI_BVALID  = s_q.bvalid;
    assign S_AXI_BRESP   = s_q.bresp;
    assign S_AXI_ARREADY = s_q.arready;
    assign S_AXI_RVALID  = s_q.rvalid;
    assign S_AXI_RDATA   = s_q.rdata;
    assign S_AXI_RRESP   = s_q.rresp;
    assign TEMP_ALARM    = s_q.alarm;
    assign TEMP_LOCKOUT  = s_q.lockout;
    assign TEMP_FALLBACK = s_q.fallback;
    assign TEMP_SUSPEND  = s_q.suspend;
    assign IRQ           = s_q.irq;

    // ============================================================
    // checks
    // ============================================================
    AST_VALVE_COUNT: assert property (@(posedge CLK) disable iff (RST)
        (MAIN_VALVE_ON && !s_q.valve_prev && !cnt_load[0] && cnt_val[0] < `CTHC_CNT_MAX)
        |=> cnt_val[0] == $past(cnt_val[0]) + 20'h00001) else $error("burner count missed valve on");
    AST_CTL_RO: assert property (@(posedge CLK) disable iff (RST)
        (!CTRL_CYCLE_EVT) |=> $stable(ctl_cnt)) else $error("control count changed without event");
    AST_NONE_REACT: assert property (@(posedge CLK) disable iff (RST)
        (temp_none[0]) |=> (TEMP_ALARM[0] ^ TEMP_LOCKOUT[0]) && (TEMP_FALLBACK[0] ^ TEMP_SUSPEND[0]))
        else $error("none code not handled");
    AST_NO_NONE_QUIET: assert property (@(posedge CLK) disable iff (RST)
        (!temp_none[1]) |=> !TEMP_ALARM[1] && !TEMP_LOCKOUT[1]) else $error("spurious temp alarm");
    AST_BRN_LOAD: assert property (@(posedge CLK) disable iff (RST)
        (cnt_load[0]) |=> cnt_val[0] <= `CTHC_CNT_MAX) else $error("burner count load out of range");
    AST_BVALID_HOLD: assert property (@(posedge CLK) disable iff (RST)
        (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID) else $error("write response dropped");
    AST_RD_ANSWER: assert property (@(posedge CLK) disable iff (RST)
        (S_AXI_ARREADY) |-> ##1 S_AXI_RVALID) else $error("read answer late");
    AST_IRQ_LEVEL: assert property (@(posedge CLK) disable iff (RST)
        IRQ == |(s_q.irq_stat & s_q.irq_mask)) else $error("irq level wrong");
endmodule : cthc_top

// ### hw/cthc_map.svh
/*
 * Register offsets, field positions, timing and limits of the
 * cycle and time history counter bank.
 * Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
 */
`ifndef CTHC_MAP_SVH
`define CTHC_MAP_SVH

// ============================================================
// register byte offsets
// ============================================================
`define CTHC_OFS_BRN_TIME   12'h000
`define CTHC_OFS_CNT_BASE   12'h004
`define CTHC_OFS_CTL_TIME   12'h01C
`define CTHC_OFS_CTL_CNT    12'h020
`define CTHC_OFS_EVT_CFG    12'h024
`define CTHC_OFS_TEMP_IN    12'h028
`define CTHC_OFS_TEMP_ACT   12'h02C
`define CTHC_OFS_IRQ_STAT   12'h030
`define CTHC_OFS_IRQ_MASK   12'h034
`define CTHC_OFS_FUNC_STAT  12'h038

// ============================================================
// fields and limits
// ============================================================
`define CTHC_CNT_MAX        20'hF423F
`define CTHC_HOUR_MAX       20'hF423F
`define CTHC_MIN_MAX        6'h3B
`define CTHC_MIN_POS        0
`define CTHC_HOUR_POS       8
`define CTHC_TEMP_NONE      16'h8000
`define CTHC_NUM_CNT        6
`define CTHC_NUM_TFUNC      4

// ============================================================
// timing: one minute at 25 MHz
// ============================================================
`define CTHC_CLK_HZ         25000000
`define CTHC_MINUTE_S       60
`define CTHC_MINUTE_CYC     (`CTHC_CLK_HZ * `CTHC_MINUTE_S)

// ============================================================
// interrupt status bits and bus response codes
// ============================================================
`define CTHC_IRQ_SAT_POS    0
`define CTHC_IRQ_NONE_POS   1
`define CTHC_IRQ_WIDTH      2
`define CTHC_RESP_OKAY      2'h0
`define CTHC_RESP_SLVERR    2'h2

`endif

// ### hw/cthc_pkg.sv
/*
 * Types shared by the counter bank modules.
 * Assumes cthc_map.svh provides the numeric constants.
 */
package cthc_pkg;

    typedef logic [19:0] cthc_cnt_t;

    typedef struct packed {
        logic [19:0] hours;
        logic [5:0]  mins;
    } cthc_time_t;

    typedef enum logic [1:0] {
        CTHC_AX_IDLE = 2'b00,
        CTHC_AX_RESP = 2'b01
    } cthc_ax_st_t;

endpackage : cthc_pkg

// ### hw/cthc_tick_if.sv
/*
 * Minute tick carrier between the top and the elapsed time counters.
 * Assumes a single clock domain.
 */
`timescale 1ns/1ps
interface cthc_tick_if;
    logic min_tick;
    modport src (output min_tick);
    modport dst (input  min_tick);
endinterface : cthc_tick_if

// ### hw/cthc_runtime.sv
/*
 * Elapsed time counter held as hours and minutes, with optional load.
 * Assumes a one-cycle minute tick from the top; load wins over the tick.
 */
`timescale 1ns/1ps
`include "cthc_map.svh"
module cthc_runtime
    import cthc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    cthc_tick_if.dst        tick,
    input  wire logic       run,
    input  wire logic       load,
    input  wire cthc_time_t load_val,
    output cthc_time_t      value
);
    typedef struct packed {
        cthc_time_t t;
    } cthc_rt_st_t;

    cthc_rt_st_t st_q;
    cthc_rt_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        if (load)
        begin
            // out of range loads clamp so both fields stay inside their digit ranges
            st_d.t.hours = (load_val.hours > `CTHC_HOUR_MAX) ? `CTHC_HOUR_MAX : load_val.hours;
            st_d.t.mins  = (load_val.mins > `CTHC_MIN_MAX) ? `CTHC_MIN_MAX : load_val.mins;
        end
        else if (tick.min_tick && run)
        begin
            if (st_q.t.mins == `CTHC_MIN_MAX)
            begin
                // hour field stops at six digits, the clock then freezes
                if (st_q.t.hours != `CTHC_HOUR_MAX)
                begin
                    st_d.t.mins  = 6'h00;
                    st_d.t.hours = st_q.t.hours + 20'h00001;
                end
            end
            else
            begin
                st_d.t.mins = st_q.t.mins + 6'h01;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign value = st_q.t;

    AST_MIN_RANGE: assert property (@(posedge clk) disable iff (rst)
        st_q.t.mins <= `CTHC_MIN_MAX) else $error("minute field out of range");
endmodule : cthc_runtime

// ### hw/cthc_evcnt.sv
/*
 * Saturating decimal-range event counter 0..999999 with load.
 * Assumes event is a one-cycle pulse; load wins over the event.
 */
`timescale 1ns/1ps
`include "cthc_map.svh"
module cthc_evcnt
    import cthc_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire logic      evt,
    input  wire logic      load,
    input  wire cthc_cnt_t load_val,
    output cthc_cnt_t      value,
    output logic           sat_hit
);
    typedef struct packed {
        cthc_cnt_t cnt;
    } cthc_ev_st_t;

    cthc_ev_st_t st_q;
    cthc_ev_st_t st_d;

    always_comb
    begin
        st_d = st_q;
        sat_hit = 1'b0;
        if (load)
        begin
            // out of range loads clamp so the counter never leaves 0..999999
            st_d.cnt = (load_val > `CTHC_CNT_MAX) ? `CTHC_CNT_MAX : load_val;
        end
        else if (evt)
        begin
            if (st_q.cnt == `CTHC_CNT_MAX)
            begin
                sat_hit = 1'b1;
            end
            else
            begin
                st_d.cnt = st_q.cnt + 20'h00001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign value = st_q.cnt;

    AST_HOLD_AT_MAX: assert property (@(posedge clk) disable iff (rst)
        (st_q.cnt == `CTHC_CNT_MAX && evt && !load) |=> st_q.cnt == `CTHC_CNT_MAX)
        else $error("counter wrapped past maximum");
    AST_COUNT_STEP: assert property (@(posedge clk) disable iff (rst)
        (st_q.cnt < `CTHC_CNT_MAX && evt && !load) |=> st_q.cnt == $past(st_q.cnt) + 20'h00001)
        else $error("counter did not advance by one");
endmodule : cthc_evcnt

// ### tb/cthc_disp_model.sv
/*
 * Display-side bus master model: one write or one read at a time.
 * Assumes the counter bank answers as the only slave on CLK.
 */
`timescale 1ns/1ps
module cthc_disp_model
(
    input  wire logic        CLK,
    output logic [11:0]      awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [11:0]      araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    int hang = 0;
    initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    // ============================================================
    // transfers; the display is the only initiator
    // ============================================================
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        begin
            n = 0;
            @(posedge CLK);
            awaddr <= a;
            wdata <= d;
            wstrb <= 4'hF;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do
            begin
                @(posedge CLK);
                n++;
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (!bvalid && n < 200);
            r = bresp;
            bready <= 1'b0;
            if (n >= 200) hang++;
        end
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        begin
            n = 0;
            @(posedge CLK);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do
            begin
                @(posedge CLK);
                n++;
                if (arready) arvalid <= 1'b0;
            end while (!rvalid && n < 200);
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            if (n >= 200) hang++;
        end
    endtask : rd
endmodule : cthc_disp_model

// ### tb/tb_top.sv
/*
 * Self-checking bench for the counter bank.
 * Assumes cthc_disp_model drives the register bus.
 */
`timescale 1ns/1ps
`include "cthc_map.svh"
module tb_top;
    logic CLK = 0, RST = 1, valve = 0, cyc = 0;
    logic [4:0] pump = '0;
    logic [63:0] temps = '0;
    logic [3:0] alm, lko, fbk, sus;
    logic irq;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdv;
    logic [3:0] ws;
    logic [1:0] br, rr;
    logic awv, awr, wv, wr_, bv, bry, arv, arr, rv, rry;
    int fails = 0, check_count = 0;
    initial forever #20 CLK = ~CLK;
    cthc_top cthc_top_i (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
        .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdv), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .MAIN_VALVE_ON(valve),
        .CTRL_CYCLE_EVT(cyc), .LOOP_PUMP_ON(pump), .TEMP_PARAMS(temps), .TEMP_ALARM(alm), .TEMP_LOCKOUT(lko),
        .TEMP_FALLBACK(fbk), .TEMP_SUSPEND(sus), .IRQ(irq));
    cthc_disp_model cthc_disp_model_i (.CLK(CLK), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd),
        .wstrb(ws), .wvalid(wv), .wready(wr_), .bresp(br), .bvalid(bv), .bready(bry), .araddr(ara),
        .arvalid(arv), .arready(arr), .rdata(rdv), .rresp(rr), .rvalid(rv), .rready(rry));
    // ============================================================
    // helpers
    // ============================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            check_count++;
            if (got !== exp)
            begin
                fails++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask : chk
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] rexp);
        logic [31:0] d;
        logic [1:0] r;
        begin
            cthc_disp_model_i.rd(a, d, r);
            if (cthc_disp_model_i.hang != 0)
                close_out();
            chk(d, exp);
            chk({30'h0, r}, {30'h0, rexp});
        end
    endtask : rchk
    task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] rexp);
        logic [1:0] r;
        begin
            cthc_disp_model_i.wr(a, d, r);
            if (cthc_disp_model_i.hang != 0)
                close_out();
            chk({30'h0, r}, {30'h0, rexp});
        end
    endtask : wchk
    // ============================================================
    // scenarios
    // ============================================================
    task automatic t_load;
        begin
            rchk(`CTHC_OFS_CNT_BASE, 32'h0, `CTHC_RESP_OKAY);
            wchk(`CTHC_OFS_BRN_TIME, 32'h0000003F, `CTHC_RESP_OKAY);
            rchk(`CTHC_OFS_BRN_TIME, 32'h0000003B, `CTHC_RESP_OKAY);
            rchk(`CTHC_OFS_CTL_TIME, 32'h0, `CTHC_RESP_OKAY);
            wchk(`CTHC_OFS_BRN_TIME, 32'h01E2403B, `CTHC_RESP_OKAY);
            rchk(`CTHC_OFS_BRN_TIME, 32'h01E2403B, `CTHC_RESP_OKAY);
            for (int i = 0; i < 6; i++) wchk(`CTHC_OFS_CNT_BASE + 12'(4 * i), 32'h100 + i, `CTHC_RESP_OKAY);
            for (int i = 0; i < 6; i++) rchk(`CTHC_OFS_CNT_BASE + 12'(4 * i), 32'h100 + i, `CTHC_RESP_OKAY);
            wchk(`CTHC_OFS_CTL_CNT, 32'h55, `CTHC_RESP_SLVERR);
            wchk(`CTHC_OFS_CTL_TIME, 32'h55, `CTHC_RESP_SLVERR);
            rchk(`CTHC_OFS_CTL_CNT, 32'h0, `CTHC_RESP_OKAY);
            rchk(12'h0FC, 32'h0, `CTHC_RESP_SLVERR);
        end
    endtask : t_load
    task automatic t_events;
        begin
            @(posedge CLK);
            valve <= 1'b1;
            pump <= 5'h1F;
            cyc <= 1'b1;
            @(posedge CLK);
            cyc <= 1'b0;
            repeat (3) @(posedge CLK);
            valve <= 1'b0;
            pump <= 5'h00;
            for (int i = 0; i < 6; i++) rchk(`CTHC_OFS_CNT_BASE + 12'(4 * i), 32'h101 + i, `CTHC_RESP_OKAY);
            rchk(`CTHC_OFS_CTL_CNT, 32'h1, `CTHC_RESP_OKAY);
        end
    endtask : t_events
    task automatic t_sat;
        begin
            wchk(`CTHC_OFS_CNT_BASE + 12'h00C, {12'h0, `CTHC_CNT_MAX}, `CTHC_RESP_OKAY);
            wchk(`CTHC_OFS_IRQ_MASK, 32'h1, `CTHC_RESP_OKAY);
            @(posedge CLK);
            pump <= 5'h04;
            repeat (3) @(posedge CLK);
            pump <= 5'h00;
            rchk(`CTHC_OFS_CNT_BASE + 12'h00C, {12'h0, `CTHC_CNT_MAX}, `CTHC_RESP_OKAY);
            chk({31'h0, irq}, 32'h1);
            wchk(`CTHC_OFS_IRQ_STAT, 32'h1, `CTHC_RESP_OKAY);
            repeat (2) @(posedge CLK);
            chk({31'h0, irq}, 32'h0);
        end
    endtask : t_sat
    task automatic t_temp;
        begin
            @(posedge CLK);
            temps <= {16'h0032, 16'h0032, 16'h0032, `CTHC_TEMP_NONE};
            repeat (3) @(posedge CLK);
            chk({16'h0, alm, lko, fbk, sus}, 32'h1010);
            wchk(`CTHC_OFS_EVT_CFG, 32'h11, `CTHC_RESP_OKAY);
            repeat (3) @(posedge CLK);
            chk({16'h0, alm, lko, fbk, sus}, 32'h0101);
            rchk(`CTHC_OFS_IRQ_STAT, 32'h2, `CTHC_RESP_OKAY);
            rchk(`CTHC_OFS_TEMP_IN, 32'h1, `CTHC_RESP_OKAY);
            rchk(`CTHC_OFS_TEMP_ACT, 32'h1010, `CTHC_RESP_OKAY);
        end
    endtask : t_temp
    task automatic close_out;
        begin
            fails += cthc_disp_model_i.hang;
            if (fails == 0 && check_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask : close_out
    initial
    begin
        repeat (8) @(posedge CLK);
        RST <= 1'b0;
        t_load();
        t_events();
        t_sat();
        t_temp();
        close_out();
    end
endmodule : tb_top
